// file: logic/pmx_defines.vh
`ifndef PMX_DEFINES_VH
`define PMX_DEFINES_VH

// Register byte addresses
`define PMX_ADDR_PORTA_CFG   8'h00
`define PMX_ADDR_PORTA_CFG2  8'h04
`define PMX_ADDR_PORTB_CFG   8'h08
`define PMX_ADDR_IFMODE      8'h0c
`define PMX_ADDR_PORTA_OUT   8'h10
`define PMX_ADDR_PORTA_OE    8'h14
`define PMX_ADDR_PORTB_OUT   8'h18
`define PMX_ADDR_PORTB_OE    8'h1c
`define PMX_ADDR_PIN_STATE   8'h20

// Interface mode field encodings
`define PMX_IF_PORTS         2'h0
`define PMX_IF_CPU_BUS       2'h1
`define PMX_IF_WAVE          2'h2
`define PMX_IF_SLAVE_FIFO    2'h3

// Reset values
`define PMX_RST_BYTE         8'h00
`define PMX_RST_IFMODE       2'h0

// UART mode 0 code
`define PMX_UART_MODE0       2'h0

// AXI responses
`define PMX_RESP_OKAY        2'h0
`define PMX_RESP_SLVERR      2'h2

// Configuration bit positions
`define PMX_A5               5
`define PMX_A6               6
`define PMX_A7               7
`define PMX_B0               0
`define PMX_B1               1
`define PMX_B2               2

`endif

// file: logic/pmx_pin_mux.v
// Function
// (R1) Port A bit 5 function from alt-select bit 5, select-two bit 5, mode.
// (R2) After reset every pin is a port input, nothing driven.
// (R3) External FIFO strobe, active low, driven out on port A bit 5.
// (R4) Waveform mode: port A bit 5 feeds waveform ready input five.
// (R5) Slave FIFO mode: outside strobe on bit 5 pops slave FIFOs.
// (R6) Port A bit 6 function chosen by alt-select bit 6 alone.
// (R7) UART0 echo drives UART0 data in mode 0, else constant one.
// (R8) Port A bit 7 function chosen by alt-select bit 7 alone.
// (R9) UART1 echo drives UART1 data in mode 0, high in modes 1-3.
// (R10) Timer2 count input taken from pad only while counter-select is one.
// (R11) Timer2 reload on each falling edge of port B bit 1.
// (R12) Reload edges ignored unless timer2 external enable is set.
// (R13) UART1 receive takes pad level in every UART mode.
// (R14) CPU bus mode: port B bits 0-2 carry processor data bits.
// (R15) Waveform mode: port B bits carry waveform A data bits.
// (R16) Slave FIFO mode: port B bits carry FIFO A data bits.
// (R17) Timer0 overflow output pulses high one cycle per overflow.
// (R18) Pads driven only for outputs or buses driving; inputs float.
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`include "pmx_defines.vh"

module pmx_pin_mux (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [2:0]  padAIn,
    output reg  [2:0]  padAOut,
    output reg  [2:0]  padAOe,
    input  wire [2:0]  padBIn,
    output reg  [2:0]  padBOut,
    output reg  [2:0]  padBOe,
    input  wire        extFifoStrobeN,
    input  wire        uart0SyncData,
    input  wire [1:0]  uart0Mode,
    input  wire        uart1SyncData,
    input  wire [1:0]  uart1Mode,
    input  wire [2:0]  cpuDataOut,
    input  wire        cpuDataDrive,
    output reg  [2:0]  cpuDataIn,
    input  wire [2:0]  waveDataOut,
    input  wire        waveDataDrive,
    output reg  [2:0]  waveDataIn,
    input  wire [2:0]  fifoADataOut,
    input  wire        fifoADataDrive,
    output reg  [2:0]  fifoADataIn,
    input  wire        timerTwoCounterSelect,
    input  wire        timerTwoExtEnable,
    input  wire        timerZeroOverflow,
    output reg         waveReadyInFive,
    output reg         slaveFifoReadStrobe,
    output reg         timerTwoCountIn,
    output reg         timerTwoReload,
    output reg         uart1ReceiveIn,
    output reg         timerZeroOverflowOut
);

    reg [7:0] portAAltSelect_q;
    reg [7:0] portAAltSelectTwo_q;
    reg [7:0] portBAltSelect_q;
    reg [1:0] ifMode_q;
    reg [7:0] portAOutLatch_q;
    reg [7:0] portAOeLatch_q;
    reg [7:0] portBOutLatch_q;
    reg [7:0] portBOeLatch_q;
    reg       reloadPrev_q;
    reg       awHeld_q;
    reg [7:0] awAddr_q;
    reg       wHeld_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;

    reg [2:0] aOut_d;
    reg [2:0] aOe_d;
    reg [2:0] bOut_d;
    reg [2:0] bOe_d;
    reg [31:0] rdData_d;
    reg        rdOk_d;

    wire doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    wire wave    = ifMode_q == `PMX_IF_WAVE;
    wire slave   = ifMode_q == `PMX_IF_SLAVE_FIFO;
    wire cpuBus  = ifMode_q == `PMX_IF_CPU_BUS;
    wire fifoStrobeSel = portAAltSelect_q[`PMX_A5]
                         && !portAAltSelectTwo_q[`PMX_A5]
                         && !wave && !slave; // R1
    wire waveReadySel  = portAAltSelectTwo_q[`PMX_A5] && wave;  // R1
    wire slaveReadSel  = portAAltSelectTwo_q[`PMX_A5] && slave; // R1
    // Raw pad edge, so leaving the function fakes no reload
    wire reloadSel = portBAltSelect_q[`PMX_B1] && !cpuBus && !wave
                     && !slave;

    // Byte-lane merge of write data
    function [7:0] mergeByte;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            mergeByte = strb[0] ? data[7:0] : old;
        end
    endfunction

    // Pad drivers
    always @* begin
        aOut_d = portAOutLatch_q[`PMX_A7:`PMX_A5];
        aOe_d  = portAOeLatch_q[`PMX_A7:`PMX_A5];
        if (fifoStrobeSel) begin
            aOut_d[0] = extFifoStrobeN; // R3
            aOe_d[0]  = 1'b1;
        end else if (waveReadySel || slaveReadSel) begin
            aOe_d[0] = 1'b0; // R4 R5 R18
        end
        if (portAAltSelect_q[`PMX_A6]) begin // R6
            aOut_d[1] = (uart0Mode == `PMX_UART_MODE0) ?
                        uart0SyncData : 1'b1; // R7
            aOe_d[1]  = 1'b1;
        end
        if (portAAltSelect_q[`PMX_A7]) begin // R8
            aOut_d[2] = (uart1Mode == `PMX_UART_MODE0) ?
                        uart1SyncData : 1'b1; // R9
            aOe_d[2]  = 1'b1;
        end
        bOut_d = portBOutLatch_q[`PMX_B2:`PMX_B0];
        bOe_d  = portBOeLatch_q[`PMX_B2:`PMX_B0];
        // Bus modes override the port B selects
        if (cpuBus) begin
            bOut_d = cpuDataOut; // R14
            bOe_d  = {3{cpuDataDrive}}; // R18
        end else if (wave) begin
            bOut_d = waveDataOut; // R15
            bOe_d  = {3{waveDataDrive}};
        end else if (slave) begin
            bOut_d = fifoADataOut; // R16
            bOe_d  = {3{fifoADataDrive}};
        end else begin
            if (portBAltSelect_q[`PMX_B0]) bOe_d[0] = 1'b0; // R18
            if (portBAltSelect_q[`PMX_B1]) bOe_d[1] = 1'b0;
            if (portBAltSelect_q[`PMX_B2]) bOe_d[2] = 1'b0;
        end
    end

    // Read decode
    always @* begin
        rdData_d = 32'h0;
        rdOk_d   = 1'b1;
        if (s_axi_araddr == `PMX_ADDR_PORTA_CFG) begin
            rdData_d[7:0] = portAAltSelect_q;
        end else if (s_axi_araddr == `PMX_ADDR_PORTA_CFG2) begin
            rdData_d[7:0] = portAAltSelectTwo_q;
        end else if (s_axi_araddr == `PMX_ADDR_PORTB_CFG) begin
            rdData_d[7:0] = portBAltSelect_q;
        end else if (s_axi_araddr == `PMX_ADDR_IFMODE) begin
            rdData_d[1:0] = ifMode_q;
        end else if (s_axi_araddr == `PMX_ADDR_PORTA_OUT) begin
            rdData_d[7:0] = portAOutLatch_q;
        end else if (s_axi_araddr == `PMX_ADDR_PORTA_OE) begin
            rdData_d[7:0] = portAOeLatch_q;
        end else if (s_axi_araddr == `PMX_ADDR_PORTB_OUT) begin
            rdData_d[7:0] = portBOutLatch_q;
        end else if (s_axi_araddr == `PMX_ADDR_PORTB_OE) begin
            rdData_d[7:0] = portBOeLatch_q;
        end else if (s_axi_araddr == `PMX_ADDR_PIN_STATE) begin
            rdData_d[5:0] = {padBIn, padAIn};
        end else begin
            rdOk_d = 1'b0;
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            portAAltSelect_q     <= `PMX_RST_BYTE; // R2
            portAAltSelectTwo_q  <= `PMX_RST_BYTE;
            portBAltSelect_q     <= `PMX_RST_BYTE;
            ifMode_q             <= `PMX_RST_IFMODE;
            portAOutLatch_q      <= `PMX_RST_BYTE;
            portAOeLatch_q       <= `PMX_RST_BYTE;
            portBOutLatch_q      <= `PMX_RST_BYTE;
            portBOeLatch_q       <= `PMX_RST_BYTE;
            reloadPrev_q         <= 1'b0;
            awHeld_q             <= 1'b0;
            awAddr_q             <= 8'h00;
            wHeld_q              <= 1'b0;
            wData_q              <= 32'h0;
            wStrb_q              <= 4'h0;
            s_axi_awready        <= 1'b0;
            s_axi_wready         <= 1'b0;
            s_axi_bvalid         <= 1'b0;
            s_axi_bresp          <= `PMX_RESP_OKAY;
            s_axi_arready        <= 1'b0;
            s_axi_rvalid         <= 1'b0;
            s_axi_rdata          <= 32'h0;
            s_axi_rresp          <= `PMX_RESP_OKAY;
            padAOut              <= 3'h0;
            padAOe               <= 3'h0;
            padBOut              <= 3'h0;
            padBOe               <= 3'h0;
            cpuDataIn            <= 3'h0;
            waveDataIn           <= 3'h0;
            fifoADataIn          <= 3'h0;
            waveReadyInFive      <= 1'b0;
            slaveFifoReadStrobe  <= 1'b0;
            timerTwoCountIn      <= 1'b0;
            timerTwoReload       <= 1'b0;
            uart1ReceiveIn       <= 1'b1;
            timerZeroOverflowOut <= 1'b0;
        end else begin
            padAOut <= aOut_d;
            padAOe  <= aOe_d;
            padBOut <= bOut_d;
            padBOe  <= bOe_d;
            cpuDataIn   <= cpuBus ? padBIn : 3'h0;
            waveDataIn  <= wave ? padBIn : 3'h0;
            fifoADataIn <= slave ? padBIn : 3'h0;
            waveReadyInFive     <= waveReadySel && padAIn[0]; // R4
            slaveFifoReadStrobe <= slaveReadSel && padAIn[0]; // R5
            timerTwoCountIn <= portBAltSelect_q[`PMX_B0] && !cpuBus && !wave
                               && !slave && timerTwoCounterSelect
                               && padBIn[0]; // R10
            reloadPrev_q   <= padBIn[1];
            timerTwoReload <= reloadSel && reloadPrev_q && !padBIn[1]
                              && timerTwoExtEnable; // R11 R12
            uart1ReceiveIn <= (portBAltSelect_q[`PMX_B2] && !cpuBus && !wave
                              && !slave) ? padBIn[2] : 1'b1; // R13
            timerZeroOverflowOut <= timerZeroOverflow; // R17

            // AXI write channels, taken in either order
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
            if (doWrite) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `PMX_RESP_OKAY;
                if (awAddr_q == `PMX_ADDR_PORTA_CFG) begin
                    portAAltSelect_q <=
                        mergeByte(portAAltSelect_q, wData_q, wStrb_q);
                end else if (awAddr_q == `PMX_ADDR_PORTA_CFG2) begin
                    portAAltSelectTwo_q <=
                        mergeByte(portAAltSelectTwo_q, wData_q, wStrb_q);
                end else if (awAddr_q == `PMX_ADDR_PORTB_CFG) begin
                    portBAltSelect_q <=
                        mergeByte(portBAltSelect_q, wData_q, wStrb_q);
                end else if (awAddr_q == `PMX_ADDR_IFMODE) begin
                    if (wStrb_q[0]) ifMode_q <= wData_q[1:0];
                end else if (awAddr_q == `PMX_ADDR_PORTA_OUT) begin
                    portAOutLatch_q <=
                        mergeByte(portAOutLatch_q, wData_q, wStrb_q);
                end else if (awAddr_q == `PMX_ADDR_PORTA_OE) begin
                    portAOeLatch_q <=
                        mergeByte(portAOeLatch_q, wData_q, wStrb_q);
                end else if (awAddr_q == `PMX_ADDR_PORTB_OUT) begin
                    portBOutLatch_q <=
                        mergeByte(portBOutLatch_q, wData_q, wStrb_q);
                end else if (awAddr_q == `PMX_ADDR_PORTB_OE) begin
                    portBOeLatch_q <=
                        mergeByte(portBOeLatch_q, wData_q, wStrb_q);
                end else if (awAddr_q != `PMX_ADDR_PIN_STATE) begin
                    s_axi_bresp <= `PMX_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end

            // AXI read channel
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdData_d;
                s_axi_rresp  <= rdOk_d ? `PMX_RESP_OKAY : `PMX_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// file: verification/pmx_pin_mux_sva.sv
module pmx_pin_mux_sva (
    input logic        clock,
    input logic        sys_rst,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic [2:0]  padAOe,
    input logic [2:0]  padBOe,
    input logic [2:0]  padBIn,
    input logic [2:0]  cpuDataIn,
    input logic [2:0]  waveDataIn,
    input logic [2:0]  fifoADataIn,
    input logic        waveReadyInFive,
    input logic        slaveFifoReadStrobe,
    input logic        timerTwoCounterSelect,
    input logic        timerTwoCountIn,
    input logic        timerTwoExtEnable,
    input logic        timerTwoReload,
    input logic        timerZeroOverflow,
    input logic        timerZeroOverflowOut
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic cfgSeen_q;
    always @(posedge clock or posedge sys_rst)
        if (sys_rst) cfgSeen_q <= 1'b0;
        else if (s_axi_awvalid && s_axi_awready) cfgSeen_q <= 1'b1;
    idle_pads_a: assert property (
        !cfgSeen_q |-> (padAOe | padBOe) == 3'h0)
        else $error("pad driven before any write");
    t0_pulse_a: assert property (
        timerZeroOverflow |=> timerZeroOverflowOut)
        else $error("overflow output missed");
    t0_quiet_a: assert property (
        !timerZeroOverflow |=> !timerZeroOverflowOut)
        else $error("overflow output too long");
    t2_count_a: assert property (
        !timerTwoCounterSelect |=> !timerTwoCountIn)
        else $error("count input not gated");
    t2_gate_a: assert property (
        !timerTwoExtEnable |=> !timerTwoReload)
        else $error("reload while disabled");
    t2_edge_a: assert property (
        timerTwoReload |-> $past(padBIn[1], 2) && !$past(padBIn[1])
        ##1 !timerTwoReload)
        else $error("reload not a fall pulse");
    in_float_a: assert property (
        waveReadyInFive || slaveFifoReadStrobe |-> !padAOe[0])
        else $error("input pad driven");
    ready_excl_a: assert property (
        !(waveReadyInFive && slaveFifoReadStrobe))
        else $error("two pad five functions");
    bus_excl_a: assert property (
        $countones({|cpuDataIn, |waveDataIn, |fifoADataIn}) <= 1)
        else $error("two buses receive");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    r_soon_a: assert property (s_axi_arvalid && s_axi_arready |->
        ##[1:3] s_axi_rvalid) else $error("read answer late");
endmodule

// file: verification/pmx_pad_world.sv
module pmx_pad_world (
    input  logic [2:0] padOut,
    input  logic [2:0] padOe,
    input  logic [2:0] farVal,
    input  logic [2:0] farEn,
    output logic [2:0] padLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clash shows unknown; nobody driving reads the pull-up
    always_comb
        for (int i = 0; i < 3; i++)
            padLevel[i] = (padOe[i] && farEn[i]) ? 1'bx : padOe[i] ? padOut[i]
                : farEn[i] ? farVal[i] : 1'b1;
endmodule

// file: verification/port_a_b_pin_function_mux_tb_top.sv
`include "pmx_defines.vh"
module port_a_b_pin_function_mux_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, uart0Mode, uart1Mode, resp;
    logic [2:0] padAIn, padAOut, padAOe, padBIn, padBOut, padBOe;
    logic [2:0] farAVal, farAEn, farBVal, farBEn, cpuDataOut, cpuDataIn;
    logic [2:0] waveDataOut, waveDataIn, fifoADataOut, fifoADataIn;
    logic extFifoStrobeN, uart0SyncData, uart1SyncData, cpuDataDrive;
    logic waveDataDrive, fifoADataDrive, timerTwoCounterSelect;
    logic timerTwoExtEnable, timerZeroOverflow, waveReadyInFive;
    logic slaveFifoReadStrobe, timerTwoCountIn, timerTwoReload;
    logic uart1ReceiveIn, timerZeroOverflowOut;
    int err_count = 0, checks = 0, cycles = 0, hits;
    pmx_pin_mux dut (.*);
    pmx_pad_world padsA (.padOut(padAOut), .padOe(padAOe), .farVal(farAVal),
        .farEn(farAEn), .padLevel(padAIn));
    pmx_pad_world padsB (.padOut(padBOut), .padOe(padBOe), .farVal(farBVal),
        .farEn(farBEn), .padLevel(padBIn));
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        @(posedge clock);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge clock);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {uart0Mode, uart1Mode, uart0SyncData, uart1SyncData} = '0;
        {farAVal, farAEn, farBVal, farBEn, timerZeroOverflow} = '0;
        {cpuDataDrive, waveDataDrive, fifoADataDrive} = '0;
        {cpuDataOut, waveDataOut, fifoADataOut} = {3'h1, 3'h2, 3'h4};
        {timerTwoCounterSelect, timerTwoExtEnable, extFifoStrobeN} = 3'b001;
        sys_rst = 1'b1;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            axr(8'(i * 4));
            chk("reset reg", rd, 0);
        end
        axr(8'h24);
        chk("unmapped resp", resp, `PMX_RESP_SLVERR);
        chk("reset oe", {padAOe, padBOe}, 0);
        axr(`PMX_ADDR_PIN_STATE);
        chk("pin state", rd, 32'h3f);
        axw(`PMX_ADDR_PORTB_OUT, 8'h05);
        chk("write resp", resp, `PMX_RESP_OKAY);
        axw(`PMX_ADDR_PORTB_OE, 8'h07);
        axr(`PMX_ADDR_PORTB_OUT);
        chk("gpio latch", rd, 32'h05);
        settle();
        chk("gpio drive", {padBOe, padBOut}, 6'h3d);
        axw(`PMX_ADDR_PORTB_OE, 8'h00);
        $display("reset test done");
        axw(`PMX_ADDR_PORTA_CFG, 8'h20);
        @(posedge clock);
        extFifoStrobeN <= 1'b0;
        settle();
        chk("strobe low", {padAOe[0], padAOut[0]}, 2'b10);
        @(posedge clock);
        extFifoStrobeN <= 1'b1;
        settle();
        chk("strobe high", padAOut[0], 1);
        axw(`PMX_ADDR_PORTA_CFG2, 8'he0);
        axw(`PMX_ADDR_IFMODE, {6'h0, `PMX_IF_WAVE});
        @(posedge clock);
        {farAEn, farAVal} <= {3'h1, 3'h1};
        settle();
        chk("wave ready", {padAOe[0], waveReadyInFive, slaveFifoReadStrobe},
            3'b010);
        axw(`PMX_ADDR_IFMODE, {6'h0, `PMX_IF_SLAVE_FIFO});
        settle();
        chk("slave read", {waveReadyInFive, slaveFifoReadStrobe}, 2'b01);
        @(posedge clock);
        {farAEn, farAVal} <= {3'h1, 3'h0};
        settle();
        chk("slave idle", {padAOe[0], slaveFifoReadStrobe}, 0);
        $display("pad five test done");
        axw(`PMX_ADDR_IFMODE, {6'h0, `PMX_IF_PORTS});
        axw(`PMX_ADDR_PORTA_CFG, 8'hc0);
        for (int m = 0; m < 4; m++) begin
            @(posedge clock);
            {uart0Mode, uart1Mode} <= {2'(m), 2'(m)};
            settle();
            chk("echo pads", {padAOe, padAOut[2:1]},
                (m == 0) ? 5'h18 : 5'h1b);
        end
        $display("echo test done");
        axw(`PMX_ADDR_PORTB_CFG, 8'h07);
        for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            timerTwoCounterSelect <= k[1];
            uart1Mode <= 2'(k);
            {farBEn, farBVal} <= {3'h7, k[0], 2'b11};
            settle();
            chk("count in", timerTwoCountIn, k[1]);
            chk("uart1 rx", uart1ReceiveIn, k[0]);
            chk("b float", padBOe, 0);
            @(posedge clock);
            timerTwoExtEnable <= k[1];
            farBVal[1] <= 1'b0;
            hits = 0;
            repeat (4) begin
                @(posedge clock);
                #1;
                hits += timerTwoReload;
            end
            chk("reloads", hits, k[1]);
        end
        $display("timer two test done");
        for (int md = 1; md < 4; md++) begin
            axw(`PMX_ADDR_IFMODE, 8'(md));
            @(posedge clock);
            farBEn <= 3'h0;
            {cpuDataDrive, waveDataDrive, fifoADataDrive} <= 3'h7;
            settle();
            chk("bus out", {padBOe, padBOut},
                {3'h7, 3'(1 << (md - 1))});
            @(posedge clock);
            {cpuDataDrive, waveDataDrive, fifoADataDrive} <= 3'h0;
            @(posedge clock);
            {farBEn, farBVal} <= {3'h7, 3'h6};
            settle();
            chk("bus in", {cpuDataIn, waveDataIn, fifoADataIn},
                9'h6 << (3 * (3 - md)));
        end
        $display("bus test done");
        @(posedge clock);
        timerZeroOverflow <= 1'b1;
        @(posedge clock);
        timerZeroOverflow <= 1'b0;
        #1;
        chk("t0 pulse", timerZeroOverflowOut, 1);
        @(posedge clock);
        #1;
        chk("t0 end", timerZeroOverflowOut, 0);
        $display("timer zero test done");
        give_verdict();
    end
endmodule
bind pmx_pin_mux pmx_pin_mux_sva sva (.clock, .sys_rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .padAOe,
    .padBOe, .padBIn, .cpuDataIn, .waveDataIn, .fifoADataIn, .waveReadyInFive,
    .slaveFifoReadStrobe, .timerTwoCounterSelect, .timerTwoCountIn,
    .timerTwoExtEnable, .timerTwoReload, .timerZeroOverflow,
    .timerZeroOverflowOut);
